// file: bench/dpi_master.sv
/*
  fieldbus master model sending process-data frames.
  assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module dpi_master (
  // clock
  input wire logic mclk_i,
  // status from the drive
  input wire logic [7:0] mode_status_byte_i,
  // process data to the drive
  output logic [7:0] cmd_o,
  output logic [7:0] mode_o,
  output logic valid_o
);
  initial begin
    cmd_o = 8'h00;
    mode_o = 8'h00;
    valid_o = 1'b0;
  end
  // the command word stands until the next frame, so enable is held
  task send(input logic [7:0] c, input logic [7:0] m);
    cmd_o = c;
    mode_o = m;
    valid_o = 1'b1;
    @(posedge mclk_i);
    #1;
    valid_o = 1'b0;
    // one idle edge keeps back-to-back frames as separate strobes
    @(posedge mclk_i);
    #1;
  endtask
  task wait_ack;
    int n;
    n = 0;
    while (mode_status_byte_i[7] !== mode_o[7] && n < 50) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask
endmodule // dpi_master

// file: bench/dpi_monitor.sv
/*
  checker of the drive status outputs against the command and level inputs.
  assumes binding onto dpi_top: one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module dpi_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // commands
  input wire logic fieldbus_mode_i,
  input wire logic pd_valid_i,
  input wire logic par_wr_i,
  // conditions and levels
  input wire logic warning_i,
  input wire logic mode_info_i,
  input wire logic mode_end_i,
  input wire logic mode_err_i,
  input wire logic home_switch_level_i,
  input wire logic negative_limit_level_i,
  input wire logic positive_limit_level_i,
  input wire logic halt_level_i,
  input wire logic safe_torque_off_chan_b_i,
  input wire logic safe_torque_off_chan_a_i,
  // watched outputs
  input wire logic power_stage_on_o,
  input wire logic brake_release_o,
  input wire logic align_move_o,
  input wire logic [15:0] drive_status_word_o,
  input wire logic [7:0] mode_status_byte_o,
  input wire logic [7:0] input_level_byte_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire [5:0] lv = {safe_torque_off_chan_a_i, safe_torque_off_chan_b_i, halt_level_i,
    positive_limit_level_i, negative_limit_level_i, home_switch_level_i};
  wire [3:0] xs = {mode_err_i, mode_end_i, mode_info_i, warning_i};
  ////////////////////////////////////////////////////////////////////////////
  property p_io; $stable(lv) [*4] |-> input_level_byte_o == {2'b00, lv}; endproperty
  a_io: assert property (p_io) else $error("input byte differs from levels");
  property p_xs;
    $stable(xs) [*4] |-> {drive_status_word_o[15:13], drive_status_word_o[7]} == xs;
  endproperty
  a_xs: assert property (p_xs) else $error("status flags differ");
  property p_br; $rose(brake_release_o) |-> $past(power_stage_on_o); endproperty
  a_br: assert property (p_br) else $error("enabled without switched on");
  property p_on; brake_release_o |-> power_stage_on_o; endproperty
  a_on: assert property (p_on) else $error("brake released with stage off");
  property p_al; align_move_o |-> power_stage_on_o && !brake_release_o; endproperty
  a_al: assert property (p_al) else $error("settling move outside switch on");
  property p_fb;
    $rose(power_stage_on_o) |-> $past(fieldbus_mode_i, 2) || $past(fieldbus_mode_i, 3);
  endproperty
  a_fb: assert property (p_fb) else $error("enabled outside fieldbus mode");
  property p_tr; $rose(power_stage_on_o) |-> $past(pd_valid_i, 2) || $past(par_wr_i, 2);
  endproperty
  a_tr: assert property (p_tr) else $error("enable without a trigger");
  property p_mt; $changed(mode_status_byte_o[7]) |-> $past(pd_valid_i, 2); endproperty
  a_mt: assert property (p_mt) else $error("toggle mirror moved alone");
  property p_me;
    $changed(mode_status_byte_o[6]) |-> $changed(mode_status_byte_o[7]);
  endproperty
  a_me: assert property (p_me) else $error("reject bit apart from mirror");
endmodule // dpi_monitor

// file: bench/tb_top.sv
/*
  self-checking bench of dpi_top with a fieldbus master model.
  assumes 25 MHz clock and a shortened settling move.
*/
`timescale 1ns/1ps
`include "dpi_map.vh"
module tb_top;
  logic mclk_i = 1'b0, nrst_i = 1'b0, fieldbus_mode_i = 1'b1, par_wr_i = 1'b0;
  logic [7:0] state_command_word_i, mode_ctrl_i;
  logic pd_valid_i, seen;
  logic [15:0] par_addr_i = 16'h0000, par_wdata_i = 16'h0000;
  logic undervoltage_i = 1'b0, encoder_ok_i = 1'b1, overspeed_i = 1'b0, err_class1_i = 1'b0;
  logic err_class234_i = 1'b0, err_fatal_i = 1'b0, err_response_done_i = 1'b0;
  logic warning_i = 1'b0, encoder_motor_i = 1'b1, homing_ok_i = 1'b0;
  logic mode_end_i = 1'b0, mode_err_i = 1'b0, mode_info_i = 1'b0;
  logic [31:0] actual_pos_i = 32'h12345678, sel_value_i = 32'h9ABCDEF0;
  logic home_switch_level_i = 1'b0, negative_limit_level_i = 1'b0;
  logic positive_limit_level_i = 1'b0, halt_level_i = 1'b0;
  logic safe_torque_off_chan_b_i = 1'b1, safe_torque_off_chan_a_i = 1'b1;
  logic [4:0] rx_byte_num_i = 5'h09;
  wire [15:0] par_rdata_o, drive_status_word_o;
  wire [7:0] rx_byte_o, mode_status_byte_o, input_level_byte_o;
  wire power_stage_on_o, brake_release_o, align_move_o;
  int fails = 0, check_count = 0;
  dpi_top #(
    .ALIGN_CYCLES(2)
  ) dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .fieldbus_mode_i(fieldbus_mode_i),
    .state_command_word_i(state_command_word_i), .mode_ctrl_i(mode_ctrl_i),
    .pd_valid_i(pd_valid_i), .par_wr_i(par_wr_i), .par_addr_i(par_addr_i),
    .par_wdata_i(par_wdata_i), .par_rdata_o(par_rdata_o),
    .undervoltage_i(undervoltage_i), .encoder_ok_i(encoder_ok_i), .overspeed_i(overspeed_i),
    .err_class1_i(err_class1_i), .err_class234_i(err_class234_i), .err_fatal_i(err_fatal_i),
    .err_response_done_i(err_response_done_i), .warning_i(warning_i),
    .encoder_motor_i(encoder_motor_i), .homing_ok_i(homing_ok_i), .mode_end_i(mode_end_i),
    .mode_err_i(mode_err_i), .mode_info_i(mode_info_i), .actual_pos_i(actual_pos_i),
    .sel_value_i(sel_value_i), .home_switch_level_i(home_switch_level_i),
    .negative_limit_level_i(negative_limit_level_i),
    .positive_limit_level_i(positive_limit_level_i), .halt_level_i(halt_level_i),
    .safe_torque_off_chan_b_i(safe_torque_off_chan_b_i),
    .safe_torque_off_chan_a_i(safe_torque_off_chan_a_i), .rx_byte_num_i(rx_byte_num_i),
    .rx_byte_o(rx_byte_o), .power_stage_on_o(power_stage_on_o),
    .brake_release_o(brake_release_o), .align_move_o(align_move_o),
    .drive_status_word_o(drive_status_word_o), .mode_status_byte_o(mode_status_byte_o),
    .input_level_byte_o(input_level_byte_o)
  );
  dpi_master m (.mclk_i(mclk_i), .mode_status_byte_i(mode_status_byte_o),
    .cmd_o(state_command_word_i), .mode_o(mode_ctrl_i), .valid_o(pd_valid_i));
  initial forever #20 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task chkb(input logic [4:0] b, input logic [7:0] e);
    rx_byte_num_i = b;
    cyc(3);
    chk(rx_byte_o, e);
  endtask
  // waits for a state code, noting any settling move on the way
  task wst(input logic [3:0] s);
    int n;
    n = 0;
    while (drive_status_word_o[3:0] !== s && n < 60) begin
      seen = seen | align_move_o;
      cyc(1);
      n++;
    end
    chk(drive_status_word_o[3:0], s);
  endtask
  task pw(input logic [15:0] a, input logic [15:0] d);
    par_addr_i = a;
    par_wdata_i = d;
    par_wr_i = 1'b1;
    cyc(1);
    par_wr_i = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_enable;
    wst(`DPI_ST_READY);
    par_addr_i = `DPI_ADDR_ALIGN;
    cyc(2);
    chk(par_rdata_o, `DPI_ALIGN_RESET);
    seen = 1'b0;
    m.send(8'h02, 8'h00);
    wst(`DPI_ST_OP_ENABLED);
    chk(power_stage_on_o, 1'b1);
    chk({seen, brake_release_o}, 2'b11);
    m.send(8'h02, 8'h83);
    m.wait_ack;
    chk(mode_status_byte_o[7:6], 2'b10);
    chk(mode_status_byte_o[3:0], 4'h3);
  endtask
  task t_disable;
    m.send(8'h03, 8'h83);
    wst(`DPI_ST_READY);
    chk(power_stage_on_o, 1'b0);
    m.send(8'h03, 8'h83);
    cyc(8);
    chk(drive_status_word_o[3:0], `DPI_ST_READY);
    m.send(8'h03, 8'h03);
    m.wait_ack;
    chk(mode_status_byte_o[7:6], 2'b01);
  endtask
  task t_param;
    pw(`DPI_ADDR_ALIGN, 16'h0000);
    seen = 1'b0;
    pw(`DPI_ADDR_CMD, 16'h0002);
    wst(`DPI_ST_OP_ENABLED);
    chk(seen, 1'b0);
    m.send(8'h04, 8'h03);
    wst(`DPI_ST_QSTOP);
    m.send(8'h05, 8'h03);
    wst(`DPI_ST_READY);
  endtask
  task t_fault;
    err_class234_i = 1'b1;
    wst(`DPI_ST_FAULT_REACT);
    err_class234_i = 1'b0;
    err_fatal_i = 1'b1;
    wst(`DPI_ST_FAULT);
    chk(drive_status_word_o[6], 1'b1);
    err_fatal_i = 1'b0;
    m.send(8'h00, 8'h03);
    m.send(8'h08, 8'h03);
    wst(`DPI_ST_READY);
    fieldbus_mode_i = 1'b0;
    m.send(8'h02, 8'h03);
    cyc(8);
    chk(drive_status_word_o[3:0], `DPI_ST_READY);
  endtask
  task t_frame;
    {safe_torque_off_chan_a_i, safe_torque_off_chan_b_i, halt_level_i} = 3'b110;
    {positive_limit_level_i, negative_limit_level_i, home_switch_level_i} = 3'b101;
    {mode_err_i, mode_end_i, mode_info_i, warning_i} = 4'b1011;
    homing_ok_i = 1'b1;
    m.send(8'h00, 8'h03);
    cyc(14);
    chk(input_level_byte_o, 8'h35);
    chk(drive_status_word_o & 16'hE080, 16'hA080);
    chk(mode_status_byte_o[5], 1'b1);
    chkb(`DPI_RX_STAT_HI, 8'hA0);
    chkb(`DPI_RX_IO, 8'h35);
    chkb(`DPI_RX_POS0, 8'h12);
    chkb(`DPI_RX_POS3, 8'h78);
    chkb(`DPI_RX_SEL0, 8'h9A);
    homing_ok_i = 1'b0;
    cyc(3);
    chk(mode_status_byte_o[5], 1'b1);
    encoder_motor_i = 1'b0;
    cyc(3);
    chk(mode_status_byte_o[5], 1'b0);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_i);
    #1;
    nrst_i = 1'b1;
    t_enable;
    t_disable;
    t_param;
    t_fault;
    t_frame;
    finish_test;
  end
  initial begin
    #200000;
    fails++;
    finish_test;
  end
endmodule // tb_top
bind dpi_top dpi_monitor mon (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .fieldbus_mode_i(fieldbus_mode_i),
  .pd_valid_i(pd_valid_i), .par_wr_i(par_wr_i), .warning_i(warning_i),
  .mode_info_i(mode_info_i), .mode_end_i(mode_end_i), .mode_err_i(mode_err_i),
  .home_switch_level_i(home_switch_level_i), .negative_limit_level_i(negative_limit_level_i),
  .positive_limit_level_i(positive_limit_level_i), .halt_level_i(halt_level_i),
  .safe_torque_off_chan_b_i(safe_torque_off_chan_b_i),
  .safe_torque_off_chan_a_i(safe_torque_off_chan_a_i), .power_stage_on_o(power_stage_on_o),
  .brake_release_o(brake_release_o), .align_move_o(align_move_o),
  .drive_status_word_o(drive_status_word_o), .mode_status_byte_o(mode_status_byte_o),
  .input_level_byte_o(input_level_byte_o)
);

// file: common/dpi_map.vh
/*
  constants of the drive process-data interface: state codes, bit positions,
  parameter addresses and reset value.
  assumes inclusion by bare name from the design files.
*/
`ifndef DPI_MAP_VH
`define DPI_MAP_VH

// operating states
`define DPI_ST_INIT 4'h1
`define DPI_ST_NOT_READY 4'h2
`define DPI_ST_SW_ON_DIS 4'h3
`define DPI_ST_READY 4'h4
`define DPI_ST_SWITCHED_ON 4'h5
`define DPI_ST_OP_ENABLED 4'h6
`define DPI_ST_QSTOP 4'h7
`define DPI_ST_FAULT_REACT 4'h8
`define DPI_ST_FAULT 4'h9

// control word bits
`define DPI_CB_DISABLE 0
`define DPI_CB_ENABLE 1
`define DPI_CB_QSTOP 2
`define DPI_CB_FRESET 3

// status word bits
`define DPI_SW_FAULT 6
`define DPI_SW_WARN 7
`define DPI_SW_HALT 8
`define DPI_SW_XINFO 13
`define DPI_SW_XEND 14
`define DPI_SW_XERR 15

// mode status byte bits
`define DPI_MS_REFOK 5
`define DPI_MS_REJECT 6
`define DPI_MS_TOGGLE 7

// parameter channel addresses and the align parameter reset value
`define DPI_ADDR_ALIGN 16'h1410
`define DPI_ADDR_CMD 16'h0001
`define DPI_ALIGN_RESET 16'h0001

// receive frame byte numbers (1-based as counted on the link)
`define DPI_RX_STAT_HI 5'h09
`define DPI_RX_STAT_LO 5'h0A
`define DPI_RX_MODE 5'h0B
`define DPI_RX_IO 5'h0C
`define DPI_RX_POS0 5'h0D
`define DPI_RX_POS3 5'h10
`define DPI_RX_SEL0 5'h11
`define DPI_RX_SEL3 5'h14

`endif

// file: logic/dpi_edge.v
/*
  rising edge and parameter-write trigger combiner for the command bits.
  assumes the process-data word is held steady between frame strobes.
*/
`timescale 1ns/1ps
`include "dpi_map.vh"

module dpi_edge #(
  parameter W = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire nrst_i,
  // process data command word and its frame strobe
  input wire [W-1:0] pd_bits_i,
  input wire pd_valid_i,
  // parameter channel command write
  input wire [W-1:0] par_bits_i,
  input wire par_wr_i,
  // one-cycle triggers
  output reg [W-1:0] trig_o
);

reg [W-1:0] last_bits;

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    last_bits <= {W{1'b0}};
    trig_o <= {W{1'b0}};
  end else begin
    if (pd_valid_i)
      last_bits <= pd_bits_i;
    // both channels may fire in one cycle; either one is enough
    trig_o <= ({W{pd_valid_i}} & pd_bits_i & ~last_bits) |
              ({W{par_wr_i}} & par_bits_i);
  end
end

endmodule // dpi_edge

// file: logic/dpi_frame_mem.v
/*
  small memory holding the twenty bytes of the receive frame.
  assumes one writer per byte per cycle; read data is registered.
*/
`timescale 1ns/1ps

module dpi_frame_mem #(
  parameter AW = 5,
  parameter DEPTH = 21
) (
  // clock
  input wire mclk_i,
  // write port
  input wire wr_i,
  input wire [AW-1:0] waddr_i,
  input wire [7:0] wdata_i,
  // read port
  input wire [AW-1:0] raddr_i,
  output reg [7:0] rdata_o
);

reg [7:0] mem [0:DEPTH-1];

always @(posedge mclk_i) begin
  if (wr_i)
    mem[waddr_i] <= wdata_i;
  rdata_o <= mem[raddr_i];
end

endmodule // dpi_frame_mem

// file: logic/dpi_top.v
/*
  process-data status and control of a drive's operating-state logic.
  assumes a single clock, a master presenting command words with a strobe,
  a parameter channel write port and a link reading frame bytes by number.
*/
`timescale 1ns/1ps
`include "dpi_map.vh"

module dpi_top #(
  parameter ALIGN_CYCLES = 16
) (
  // clock and reset
  input wire mclk_i,
  input wire nrst_i,
  // control mode and process data from the master
  input wire fieldbus_mode_i,
  input wire [7:0] state_command_word_i,
  input wire [7:0] mode_ctrl_i,
  input wire pd_valid_i,
  // parameter channel
  input wire par_wr_i,
  input wire [15:0] par_addr_i,
  input wire [15:0] par_wdata_i,
  output reg [15:0] par_rdata_o,
  // drive conditions
  input wire undervoltage_i,
  input wire encoder_ok_i,
  input wire overspeed_i,
  input wire err_class1_i,
  input wire err_class234_i,
  input wire err_fatal_i,
  input wire err_response_done_i,
  input wire warning_i,
  input wire encoder_motor_i,
  input wire homing_ok_i,
  input wire mode_end_i,
  input wire mode_err_i,
  input wire mode_info_i,
  input wire [31:0] actual_pos_i,
  input wire [31:0] sel_value_i,
  // input pin levels
  input wire home_switch_level_i,
  input wire negative_limit_level_i,
  input wire positive_limit_level_i,
  input wire halt_level_i,
  input wire safe_torque_off_chan_b_i,
  input wire safe_torque_off_chan_a_i,
  // receive frame read port
  input wire [4:0] rx_byte_num_i,
  output reg [7:0] rx_byte_o,
  // drive outputs
  output reg power_stage_on_o,
  output reg brake_release_o,
  output reg align_move_o,
  output reg [15:0] drive_status_word_o,
  output reg [7:0] mode_status_byte_o,
  output reg [7:0] input_level_byte_o
);

////////////////////////////////////////////////////////////////////////////////

reg [3:0] state;
reg [3:0] next_state;
reg [15:0] shaft_align_on_enable;
reg [3:0] sel_mode;
reg ref_ok;
reg reject;
reg toggle;
reg [7:0] cnt;
reg [4:0] wr_ptr;
reg wr_busy;
wire [3:0] trig;
wire [7:0] mem_rdata;
wire sto_ok;
wire cmd_wr;

assign sto_ok = safe_torque_off_chan_a_i & safe_torque_off_chan_b_i;
assign cmd_wr = par_wr_i & (par_addr_i == `DPI_ADDR_CMD) & fieldbus_mode_i;

function [7:0] pos_byte;
  input [31:0] v;
  input [1:0] idx;
  begin
    pos_byte = v[8*(3-idx) +: 8];
  end
endfunction

dpi_edge #(
  .W(4)
) u_edge (
  .mclk_i(mclk_i),
  .nrst_i(nrst_i),
  .pd_bits_i(state_command_word_i[3:0]),
  .pd_valid_i(pd_valid_i & fieldbus_mode_i),
  .par_bits_i(par_wdata_i[3:0]),
  .par_wr_i(cmd_wr),
  .trig_o(trig)
);

////////////////////////////////////////////////////////////////////////////////
// operating-state machine

always @* begin
  next_state = state;
  case (state)
    `DPI_ST_INIT: next_state = `DPI_ST_NOT_READY;
    `DPI_ST_NOT_READY: next_state = `DPI_ST_SW_ON_DIS;
    `DPI_ST_SW_ON_DIS: begin
      if (!undervoltage_i || encoder_ok_i || !overspeed_i || sto_ok)
        next_state = `DPI_ST_READY;
    end
    `DPI_ST_READY: begin
      if (undervoltage_i || !sto_ok || overspeed_i)
        next_state = `DPI_ST_SW_ON_DIS;
      else if (trig[`DPI_CB_ENABLE])
        next_state = `DPI_ST_SWITCHED_ON;
    end
    `DPI_ST_SWITCHED_ON: begin
      if (trig[`DPI_CB_DISABLE])
        next_state = `DPI_ST_SW_ON_DIS;
      else if (cnt == 8'h00)
        next_state = `DPI_ST_OP_ENABLED;
    end
    `DPI_ST_OP_ENABLED: begin
      if (trig[`DPI_CB_DISABLE])
        next_state = `DPI_ST_SW_ON_DIS;
      else if (trig[`DPI_CB_QSTOP] || err_class1_i)
        next_state = `DPI_ST_QSTOP;
    end
    `DPI_ST_QSTOP: begin
      if (trig[`DPI_CB_DISABLE])
        next_state = `DPI_ST_SW_ON_DIS;
      else if (trig[`DPI_CB_FRESET])
        next_state = `DPI_ST_OP_ENABLED;
    end
    `DPI_ST_FAULT_REACT: begin
      if (err_response_done_i || err_fatal_i)
        next_state = `DPI_ST_FAULT;
    end
    `DPI_ST_FAULT: begin
      if (trig[`DPI_CB_FRESET])
        next_state = `DPI_ST_SW_ON_DIS;
    end
    default: next_state = `DPI_ST_INIT;
  endcase
  if (err_class234_i && state != `DPI_ST_FAULT_REACT && state != `DPI_ST_FAULT)
    next_state = `DPI_ST_FAULT_REACT;
end

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    state <= `DPI_ST_INIT;
    cnt <= 8'h00;
    power_stage_on_o <= 1'b0;
    brake_release_o <= 1'b0;
    align_move_o <= 1'b0;
  end else begin
    state <= next_state;
    if (next_state == `DPI_ST_SWITCHED_ON && state != `DPI_ST_SWITCHED_ON)
      cnt <= (shaft_align_on_enable[0]) ? ALIGN_CYCLES[7:0] : 8'h00;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    power_stage_on_o <= (next_state == `DPI_ST_SWITCHED_ON) ||
                        (next_state == `DPI_ST_OP_ENABLED) ||
                        (next_state == `DPI_ST_QSTOP);
    brake_release_o <= (next_state == `DPI_ST_OP_ENABLED);
    align_move_o <= (next_state == `DPI_ST_SWITCHED_ON) && shaft_align_on_enable[0] &&
                    (cnt != 8'h01) ;
  end
end

////////////////////////////////////////////////////////////////////////////////
// parameter channel and mode handshake

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    shaft_align_on_enable <= `DPI_ALIGN_RESET;
    par_rdata_o <= 16'h0000;
    sel_mode <= 4'h0;
    reject <= 1'b0;
    toggle <= 1'b0;
    ref_ok <= 1'b0;
  end else begin
    if (par_wr_i && par_addr_i == `DPI_ADDR_ALIGN)
      shaft_align_on_enable <= par_wdata_i;
    par_rdata_o <= (par_addr_i == `DPI_ADDR_ALIGN) ? shaft_align_on_enable : 16'h0000;
    if (pd_valid_i && fieldbus_mode_i && mode_ctrl_i[`DPI_MS_TOGGLE] != toggle) begin
      toggle <= mode_ctrl_i[`DPI_MS_TOGGLE];
      if (state == `DPI_ST_OP_ENABLED) begin
        sel_mode <= mode_ctrl_i[3:0];
        reject <= 1'b0;
      end else
        reject <= 1'b1;
    end
    if (homing_ok_i)
      ref_ok <= 1'b1;
    else if (!encoder_motor_i && !power_stage_on_o)
      ref_ok <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// status words

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    drive_status_word_o <= 16'h0000;
    mode_status_byte_o <= 8'h00;
    input_level_byte_o <= 8'h00;
  end else begin
    drive_status_word_o <= 16'h0000;
    drive_status_word_o[3:0] <= state;
    drive_status_word_o[`DPI_SW_FAULT] <= (state == `DPI_ST_FAULT) ||
                                          (state == `DPI_ST_FAULT_REACT);
    drive_status_word_o[`DPI_SW_WARN] <= warning_i;
    drive_status_word_o[`DPI_SW_HALT] <= halt_level_i;
    drive_status_word_o[`DPI_SW_XINFO] <= mode_info_i;
    drive_status_word_o[`DPI_SW_XEND] <= mode_end_i;
    drive_status_word_o[`DPI_SW_XERR] <= mode_err_i;
    mode_status_byte_o <= {toggle, reject, ref_ok, 1'b0, sel_mode};
    input_level_byte_o <= {2'b00, safe_torque_off_chan_a_i, safe_torque_off_chan_b_i,
                           halt_level_i, positive_limit_level_i,
                           negative_limit_level_i, home_switch_level_i};
  end
end

////////////////////////////////////////////////////////////////////////////////
// receive frame: bytes 9-20 refreshed as one block on a frame strobe that finds the writer idle

reg [7:0] wr_data;
reg [55:0] snap;

always @* begin
  wr_data = 8'h00;
  if (wr_ptr == `DPI_RX_STAT_HI)
    wr_data = drive_status_word_o[15:8];
  else if (wr_ptr == `DPI_RX_STAT_LO)
    wr_data = snap[55:48];
  else if (wr_ptr == `DPI_RX_MODE)
    wr_data = snap[47:40];
  else if (wr_ptr == `DPI_RX_IO)
    wr_data = snap[39:32];
  else if (wr_ptr <= `DPI_RX_POS3)
    wr_data = pos_byte(snap[31:0], wr_ptr[1:0] - 2'b01);
  else
    wr_data = pos_byte(sel_value_i, wr_ptr[1:0] - 2'b01);
end

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    wr_ptr <= `DPI_RX_STAT_HI;
    wr_busy <= 1'b0;
  end else if (!wr_busy) begin
    if (pd_valid_i) begin
      wr_busy <= 1'b1;
      wr_ptr <= `DPI_RX_STAT_HI;
    end
  end else if (wr_ptr == `DPI_RX_SEL3) begin
    wr_busy <= 1'b0;
  end else begin
    wr_ptr <= wr_ptr + 5'h01;
  end
end

// bytes 10-16 are frozen at the edge that writes byte 9, so 9-16 form one snapshot
always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i)
    snap <= 56'h00000000000000;
  else if (wr_busy && wr_ptr == `DPI_RX_STAT_HI)
    snap <= {drive_status_word_o[7:0], mode_status_byte_o, input_level_byte_o,
             actual_pos_i};
end

dpi_frame_mem #(
  .AW(5),
  .DEPTH(21)
) u_mem (
  .mclk_i(mclk_i),
  .wr_i(wr_busy),
  .waddr_i(wr_ptr),
  .wdata_i(wr_data),
  .raddr_i(rx_byte_num_i),
  .rdata_o(mem_rdata)
);

always @(posedge mclk_i or negedge nrst_i) begin
  if (!nrst_i)
    rx_byte_o <= 8'h00;
  else
    rx_byte_o <= mem_rdata;
end

endmodule // dpi_top
